// ===== src/ncss_top.sv
`timescale 1ns/100ps
`default_nettype none
module ncss_top
   import ncss_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   // Parameter access
   input  wire logic             prm_wr,
   input  wire logic             prm_rd,
   input  wire logic [2:0]       prm_idx,
   input  wire logic [31:0]      prm_wdata,
   output logic      [31:0]      prm_rdata_q,
   output logic                  prm_rvalid_q,
   // Object dictionary writes from the master
   input  wire logic             obj_wr,
   input  wire logic [1:0]       obj_idx,
   input  wire logic [31:0]      obj_wdata,
   // Network events
   input  wire logic             sync_event,
   input  wire logic             pdo_updated,
   input  wire logic             rx_alarm_clear,
   // Motion status
   input  wire logic             abs_pos_enabled,
   input  wire logic             homing_done,
   input  wire logic             op_start,
   // Device detail sources
   input  wire logic [31:0]      warn_detail_in,
   input  wire logic [31:0]      err_detail_in,
   input  wire logic             latch_clear,
   // Results
   output logic                  endless_feed_enable_q,
   output logic                  object_attribute_select_q,
   output logic      [4:0]       rx_mappable_q,
   output logic      [4:0]       tx_mappable_q,
   output logic      [31:0]      cycle_time_out_q,
   output logic      [31:0]      cycle_time_in_q,
   output logic                  parameter_error_alarm_q,
   output logic                  receive_data_error_alarm_q,
   output logic                  homing_incomplete_warning_q,
   output logic      [THR_W-1:0] sync_err_count_q,
   output logic      [31:0]      active_warn_q,
   output logic      [31:0]      latched_warn_q,
   output logic      [31:0]      active_err_q,
   output logic      [31:0]      latched_err_q
);

   ////////////////////////////////////////////////////////////////////
   // Parameter storage

   logic [31:0]      feed_function_select_q;
   logic [31:0]      comm_mode_setting_q;
   logic [31:0]      cycle_initial_setting_q;
   logic [THR_W-1:0] sync_error_threshold_q;
   logic [31:0]      warning_mask_word_q;
   logic [31:0]      error_mask_word_q;
   logic             cyc_load_q;
   logic             feed_chg_pend_q;
   logic [31:0]      dec_period;
   logic             dec_valid;
   logic             wr_feed;
   logic             wr_cyc;

   assign wr_feed = prm_wr && prm_idx == PRM_FEED_SEL;
   assign wr_cyc  = prm_wr && prm_idx == PRM_CYCLE_INIT;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         feed_function_select_q  <= RST_FEED_SEL;
         comm_mode_setting_q     <= RST_COMM_MODE;
         cycle_initial_setting_q <= RST_CYCLE_INIT;
      end else if (prm_wr) begin
         case (prm_idx)
            PRM_FEED_SEL:   feed_function_select_q  <= prm_wdata; // [R1]
            PRM_COMM_MODE:  comm_mode_setting_q     <= prm_wdata; // [R3]
            PRM_CYCLE_INIT: cycle_initial_setting_q <= prm_wdata;
            default: ;
         endcase
      end
   end

   // Parameter side and object side share one storage, parameter wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_error_threshold_q <= RST_SYNC_THR;
         warning_mask_word_q    <= RST_MASK;
         error_mask_word_q      <= RST_MASK;
      end else if (prm_wr) begin
         case (prm_idx)
            PRM_SYNC_THR:  sync_error_threshold_q <= prm_wdata[THR_W-1:0];
            PRM_WARN_MASK: warning_mask_word_q    <= prm_wdata;
            PRM_ERR_MASK:  error_mask_word_q      <= prm_wdata;
            default: ;
         endcase
      end else if (obj_wr) begin
         case (obj_idx)
            OBJ_SYNC_LIMIT:                                   // [R15]
               sync_error_threshold_q <= obj_wdata[THR_W-1:0];
            OBJ_WARN_MASK:  warning_mask_word_q    <= obj_wdata; // [R16]
            OBJ_ERR_MASK:   error_mask_word_q      <= obj_wdata; // [R17]
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Communication cycle

   ncss_cycle_decode u_dec (
      .code      (cycle_initial_setting_q[7:0]),
      .period_ns (dec_period),
      .valid     (dec_valid)
   );

   // Load once after reset and after each write of the setting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cyc_load_q <= 1'b1;
      end else begin
         cyc_load_q <= wr_cyc;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cycle_time_out_q <= NS_250US;
         cycle_time_in_q  <= NS_250US;
      end else if (cyc_load_q && dec_valid) begin
         cycle_time_out_q <= dec_period;           // [R5]
         cycle_time_in_q  <= dec_period;
      end else if (obj_wr && obj_idx == OBJ_CYCLE_TIME && !prm_wr) begin
         cycle_time_out_q <= obj_wdata;            // [R9]
         cycle_time_in_q  <= obj_wdata;
      end
   end

   // Bad code keeps the old period; alarm stands until a good code
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         parameter_error_alarm_q <= 1'b0;
      end else begin
         parameter_error_alarm_q <= !dec_valid;    // [R8]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Feed and attribute selections

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         endless_feed_enable_q     <= 1'b0;
         object_attribute_select_q <= 1'b0;
         rx_mappable_q             <= MAP_NEW_RX;
         tx_mappable_q             <= MAP_NEW_TX;
      end else begin
         endless_feed_enable_q <= feed_function_select_q[FEED_EN_BIT]; // [R1]
         object_attribute_select_q <= comm_mode_setting_q[ATTR_SEL_BIT];
         rx_mappable_q <= comm_mode_setting_q[ATTR_SEL_BIT]
                          ? MAP_OLD_RX : MAP_NEW_RX;  // [R4]
         tx_mappable_q <= comm_mode_setting_q[ATTR_SEL_BIT]
                          ? MAP_OLD_TX : MAP_NEW_TX;  // [R4]
      end
   end

   // Homing demand: set wins over homing_done in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         feed_chg_pend_q <= 1'b0;
      end else if (wr_feed && abs_pos_enabled
                   && prm_wdata[FEED_EN_BIT]
                      != feed_function_select_q[FEED_EN_BIT]) begin
         feed_chg_pend_q <= 1'b1;                  // [R2]
      end else if (homing_done) begin
         feed_chg_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         homing_incomplete_warning_q <= 1'b0;
      end else if (op_start && feed_chg_pend_q) begin
         homing_incomplete_warning_q <= 1'b1;      // [R2]
      end else if (homing_done) begin
         homing_incomplete_warning_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Receive data supervision

   ncss_sync_err_counter u_cnt (
      .clk         (clk),
      .rst         (rst),
      .sync_event  (sync_event),
      .pdo_updated (pdo_updated),
      .clear       (rx_alarm_clear),
      .threshold   (sync_error_threshold_q),
      .count_q     (sync_err_count_q),
      .alarm_q     (receive_data_error_alarm_q)
   );

   ////////////////////////////////////////////////////////////////////
   // Detail masking; latched bits: new detail wins over clear

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_warn_q  <= '0;
         active_err_q   <= '0;
         latched_warn_q <= '0;
         latched_err_q  <= '0;
      end else begin
         active_warn_q  <= warn_detail_in & warning_mask_word_q;  // [R16]
         active_err_q   <= err_detail_in & error_mask_word_q;     // [R17]
         latched_warn_q <= (latch_clear ? '0 : latched_warn_q)
                           | (warn_detail_in & warning_mask_word_q);
         latched_err_q  <= (latch_clear ? '0 : latched_err_q)
                           | (err_detail_in & error_mask_word_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read back

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prm_rdata_q  <= '0;
         prm_rvalid_q <= 1'b0;
      end else begin
         prm_rvalid_q <= prm_rd;
         if (prm_rd) begin
            case (prm_idx)
               PRM_FEED_SEL:   prm_rdata_q <= feed_function_select_q;
               PRM_COMM_MODE:  prm_rdata_q <= comm_mode_setting_q;
               PRM_CYCLE_INIT: prm_rdata_q <= cycle_initial_setting_q;
               PRM_SYNC_THR:   prm_rdata_q <= {17'h0,
                                               sync_error_threshold_q};
               PRM_WARN_MASK:  prm_rdata_q <= warning_mask_word_q;
               PRM_ERR_MASK:   prm_rdata_q <= error_mask_word_q;
               PRM_CYC_OUT:    prm_rdata_q <= cycle_time_out_q;
               PRM_CYC_IN:     prm_rdata_q <= cycle_time_in_q;
               default:        prm_rdata_q <= '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   logic [15:0] cnt_ext;
   logic [15:0] thr_ext;

   assign cnt_ext = {1'b0, sync_err_count_q};
   assign thr_ext = {1'b0, sync_error_threshold_q};

   sequence s_feed_change;
      wr_feed && abs_pos_enabled && !homing_done
      && prm_wdata[FEED_EN_BIT] != feed_function_select_q[FEED_EN_BIT];
   endsequence

   sequence s_start_no_homing;
      op_start && !homing_done;
   endsequence

   sequence s_quiet_miss;
      sync_event && !pdo_updated && !rx_alarm_clear && !prm_wr && !obj_wr
      && !receive_data_error_alarm_q && thr_ext != 16'h0000
      && cnt_ext + CNT_MISS_STEP < thr_ext;
   endsequence

   a_homing_warn_set: assert property (@(posedge clk) disable iff (rst) // [R2]
      s_feed_change ##1 (!homing_done)[*3] ##1 s_start_no_homing
      |=> homing_incomplete_warning_q)
      else $error("homing warning not raised");

   a_miss_adds_three: assert property (@(posedge clk) // [R10]
      disable iff (rst)
      s_quiet_miss |=> cnt_ext == $past(cnt_ext) + CNT_MISS_STEP)
      else $error("missed update did not add three");

   a_update_minus_one: assert property (@(posedge clk) // [R11]
      disable iff (rst)
      sync_event && pdo_updated && !rx_alarm_clear && !prm_wr && !obj_wr
      && !receive_data_error_alarm_q && cnt_ext != 16'h0000
      |=> cnt_ext == $past(cnt_ext) - CNT_OK_STEP)
      else $error("proper update did not subtract one");

   a_count_floor: assert property (@(posedge clk) disable iff (rst) // [R18]
      sync_event && pdo_updated && cnt_ext == 16'h0000 |=> cnt_ext == 16'h0000)
      else $error("counter went below zero");

   a_alarm_at_thr: assert property (@(posedge clk) disable iff (rst) // [R12]
      sync_event && !pdo_updated && !rx_alarm_clear && !prm_wr && !obj_wr
      && thr_ext != 16'h0000 && cnt_ext + CNT_MISS_STEP >= thr_ext
      |=> receive_data_error_alarm_q && cnt_ext == $past(thr_ext))
      else $error("alarm not raised at threshold");

   a_zero_disables: assert property (@(posedge clk) disable iff (rst) // [R13]
      thr_ext == 16'h0000 |=> !receive_data_error_alarm_q)
      else $error("alarm with detection disabled");

   a_hold_at_thr: assert property (@(posedge clk) disable iff (rst) // [R14]
      receive_data_error_alarm_q && !rx_alarm_clear && thr_ext != 16'h0000
      && $stable(thr_ext) |=> cnt_ext == $past(thr_ext))
      else $error("counter left threshold after alarm");

   a_cycle_zero_load: assert property (@(posedge clk) disable iff (rst) // [R7]
      wr_cyc && prm_wdata[7:0] == CYC_AUTO ##1 !wr_cyc
      |=> cycle_time_out_q == NS_250US && cycle_time_in_q == NS_250US)
      else $error("cycle code zero did not load 250000 ns");

   a_bad_code_alarm: assert property (@(posedge clk) disable iff (rst) // [R8]
      !dec_valid |=> parameter_error_alarm_q)
      else $error("unsupported cycle code without alarm");

   a_warn_mask: assert property (@(posedge clk) disable iff (rst) // [R16]
      1'b1 |=> active_warn_q == ($past(warn_detail_in)
                                 & $past(warning_mask_word_q)))
      else $error("warning mask not applied");

   a_attr_map: assert property (@(posedge clk) disable iff (rst) // [R4]
      comm_mode_setting_q[ATTR_SEL_BIT] && $stable(comm_mode_setting_q)
      |=> rx_mappable_q == MAP_OLD_RX && tx_mappable_q == MAP_OLD_TX)
      else $error("older mapping attributes not applied");

endmodule
`default_nettype wire

// ===== src/ncss_pkg.sv
// Summary of operation
// [R1] Endless-feed select digit: 0 disables, 1 enables the function.
// [R2] Feed change under absolute detection, no homing: warning at start.
// [R3] Attribute digit 0 gives newer mapping attributes, 1 the older set.
// [R4] Selection 0: five objects receive-only; 1: transmit, torque both ways.
// [R5] Cycle initial setting is copied into both cycle time objects.
// [R6] Cycle codes 00,04..0A decode to 250us,125us..8ms periods.
// [R7] Cycle setting zero loads 250000 ns into both cycle time objects.
// [R8] Unsupported cycle code raises the parameter error alarm.
// [R9] Master may write cycle time objects, else initial setting applies.
// [R10] Sync event without process-data update adds three to error counter.
// [R11] Sync event with proper update subtracts one from error counter.
// [R12] Count at threshold raises receive alarm; limit 0..32767, default 9.
// [R13] Threshold zero disables receive-data error detection entirely.
// [R14] After the alarm the counter holds at the threshold value.
// [R15] Threshold mirrors the sync error counter limit object sub-entry.
// [R16] Warning mask, default ones (code resets it to 0fff_ffff), gates warning details; mirrors its object.
// [R17] Error mask, default ones (code resets it to 0fff_ffff), gates error details; mirrors its object.
// [R18] Error counter never goes below zero.
package ncss_pkg;

   // Parameter port indices
   localparam logic [2:0]  PRM_FEED_SEL    = 3'h0;
   localparam logic [2:0]  PRM_COMM_MODE   = 3'h1;
   localparam logic [2:0]  PRM_CYCLE_INIT  = 3'h2;
   localparam logic [2:0]  PRM_SYNC_THR    = 3'h3;
   localparam logic [2:0]  PRM_WARN_MASK   = 3'h4;
   localparam logic [2:0]  PRM_ERR_MASK    = 3'h5;
   localparam logic [2:0]  PRM_CYC_OUT     = 3'h6;
   localparam logic [2:0]  PRM_CYC_IN      = 3'h7;

   // Object port indices
   localparam logic [1:0]  OBJ_SYNC_LIMIT  = 2'h0;
   localparam logic [1:0]  OBJ_WARN_MASK   = 2'h1;
   localparam logic [1:0]  OBJ_ERR_MASK    = 2'h2;
   localparam logic [1:0]  OBJ_CYCLE_TIME  = 2'h3;

   // Reset values
   localparam logic [31:0] RST_FEED_SEL    = 32'h0000_0000;
   localparam logic [31:0] RST_COMM_MODE   = 32'h0000_0000;
   localparam logic [31:0] RST_CYCLE_INIT  = 32'h0000_0000;
   localparam logic [14:0] RST_SYNC_THR    = 15'h0009;
   localparam logic [31:0] RST_MASK        = 32'h0fff_ffff;

   // Field positions
   localparam int          FEED_EN_BIT     = 0;
   localparam int          ATTR_SEL_BIT    = 12;
   localparam int          THR_W           = 15;

   // Error counter steps
   localparam logic [15:0] CNT_MISS_STEP   = 16'h0003;
   localparam logic [15:0] CNT_OK_STEP     = 16'h0001;

   // Cycle codes and periods in ns
   localparam logic [7:0]  CYC_AUTO        = 8'h00;
   localparam logic [7:0]  CYC_125US       = 8'h04;
   localparam logic [7:0]  CYC_250US       = 8'h05;
   localparam logic [7:0]  CYC_500US       = 8'h06;
   localparam logic [7:0]  CYC_1MS         = 8'h07;
   localparam logic [7:0]  CYC_2MS         = 8'h08;
   localparam logic [7:0]  CYC_4MS         = 8'h09;
   localparam logic [7:0]  CYC_8MS         = 8'h0a;
   localparam logic [31:0] NS_125US        = 32'd125000;
   localparam logic [31:0] NS_250US        = 32'd250000;
   localparam logic [31:0] NS_500US        = 32'd500000;
   localparam logic [31:0] NS_1MS          = 32'd1000000;
   localparam logic [31:0] NS_2MS          = 32'd2000000;
   localparam logic [31:0] NS_4MS          = 32'd4000000;
   localparam logic [31:0] NS_8MS          = 32'd8000000;

   // Mapping attribute vectors: bit0 max torque, 1 home offset,
   // 2 max motor speed, 3 encoder increments, 4 motor revolutions
   localparam logic [4:0]  MAP_NEW_RX      = 5'h1f;
   localparam logic [4:0]  MAP_NEW_TX      = 5'h00;
   localparam logic [4:0]  MAP_OLD_RX      = 5'h01;
   localparam logic [4:0]  MAP_OLD_TX      = 5'h1f;

endpackage

// ===== src/ncss_cycle_decode.sv
`timescale 1ns/100ps
`default_nettype none
module ncss_cycle_decode
   import ncss_pkg::*;
(
   input  wire logic [7:0]  code,
   output logic      [31:0] period_ns,
   output logic             valid
);

   always_comb begin
      valid     = 1'b1;
      period_ns = NS_250US;
      case (code)                                   // [R6]
         CYC_AUTO:  period_ns = NS_250US;           // [R7]
         CYC_125US: period_ns = NS_125US;
         CYC_250US: period_ns = NS_250US;
         CYC_500US: period_ns = NS_500US;
         CYC_1MS:   period_ns = NS_1MS;
         CYC_2MS:   period_ns = NS_2MS;
         CYC_4MS:   period_ns = NS_4MS;
         CYC_8MS:   period_ns = NS_8MS;
         default:   valid     = 1'b0;               // [R8]
      endcase
   end

endmodule
`default_nettype wire

// ===== src/ncss_sync_err_counter.sv
`timescale 1ns/100ps
`default_nettype none
module ncss_sync_err_counter
   import ncss_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             sync_event,
   input  wire logic             pdo_updated,
   input  wire logic             clear,
   input  wire logic [THR_W-1:0] threshold,
   output logic      [THR_W-1:0] count_q,
   output logic                  alarm_q
);

   logic [15:0] up;

   // A miss in the clear cycle counts from zero: the new event wins
   assign up = {1'b0, (clear ? {THR_W{1'b0}} : count_q)} + CNT_MISS_STEP;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= '0;
         alarm_q <= 1'b0;
      end else if (threshold == '0) begin           // [R13]
         count_q <= '0;
         alarm_q <= 1'b0;
      end else if (alarm_q && !clear) begin
         count_q <= threshold;                      // [R14]
      end else if (sync_event && !pdo_updated) begin
         if (up >= {1'b0, threshold}) begin         // [R12]
            count_q <= threshold;
            alarm_q <= 1'b1;
         end else begin
            count_q <= up[THR_W-1:0];               // [R10]
            alarm_q <= 1'b0;
         end
      end else if (clear) begin
         count_q <= '0;
         alarm_q <= 1'b0;
      end else if (sync_event && count_q != '0) begin // [R18]
         count_q <= count_q - CNT_OK_STEP[THR_W-1:0]; // [R11]
      end
   end

endmodule
`default_nettype wire

// ===== sim/ncss_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module ncss_master_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        go,
   input  wire logic [7:0]  miss_mask,
   input  wire logic [3:0]  n_ev,
   input  wire logic        ow_go,
   input  wire logic [1:0]  ow_idx,
   input  wire logic [31:0] ow_data,
   output logic             sync_event,
   output logic             pdo_updated,
   output logic             obj_wr,
   output logic      [1:0]  obj_idx,
   output logic      [31:0] obj_wdata,
   output logic             busy
);
   logic [3:0] left_q;
   logic [2:0] pos_q;
   ////////////////////////////////////////////////////////////////////////
   // Object writes; data toggles when idle so stale values never match
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         obj_wr    <= 1'b0;
         obj_idx   <= 2'h0;
         obj_wdata <= 32'h0;
      end else begin
         obj_wr <= ow_go;
         if (ow_go) begin
            obj_idx   <= ow_idx;
            obj_wdata <= ow_data;
         end else begin
            obj_wdata <= ~obj_wdata;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Sync events every other cycle, update flag from the miss mask
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         left_q      <= 4'h0;
         pos_q       <= 3'h0;
         busy        <= 1'b0;
         sync_event  <= 1'b0;
         pdo_updated <= 1'b0;
      end else if (go) begin
         left_q <= n_ev;
         pos_q  <= 3'h0;
         busy   <= 1'b1;
      end else if (left_q != 4'h0 && !sync_event) begin
         sync_event  <= 1'b1;
         pdo_updated <= ~miss_mask[pos_q];
         pos_q       <= pos_q + 3'h1;
         left_q      <= left_q - 4'h1;
      end else begin
         sync_event  <= 1'b0;
         pdo_updated <= ~pdo_updated;
         busy        <= (left_q != 4'h0);
      end
   end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import ncss_pkg::*;
   typedef struct packed {
      logic [7:0]  code;
      logic [31:0] ns;
      logic        alarm;
   } ncss_row_s;
   logic clk, rst, prm_wr, prm_rd, rx_alarm_clear, abs_pos_enabled;
   logic homing_done, op_start, latch_clear, go, ow_go;
   logic sync_event, pdo_updated, obj_wr, busy, rvalid, feed, attr;
   logic perr, rxerr, hwarn;
   logic [1:0]       ow_idx, obj_idx;
   logic [2:0]       prm_idx;
   logic [3:0]       n_ev;
   logic [4:0]       rxm, txm;
   logic [7:0]       miss_mask;
   logic [THR_W-1:0] cnt;
   logic [31:0]      prm_wdata, ow_data, obj_wdata, rdata, wdi, edi, v;
   logic [31:0]      cto, cti, awarn, lwarn, aerr, lerr;
   int               fails, total_checks;
   ncss_row_s        rows [10];
   ////////////////////////////////////////////////////////////////////////
   ncss_top i_ncss_top (.clk(clk), .rst(rst), .prm_wr(prm_wr),
      .prm_rd(prm_rd), .prm_idx(prm_idx), .prm_wdata(prm_wdata),
      .prm_rdata_q(rdata), .prm_rvalid_q(rvalid), .obj_wr(obj_wr),
      .obj_idx(obj_idx), .obj_wdata(obj_wdata), .sync_event(sync_event),
      .pdo_updated(pdo_updated), .rx_alarm_clear(rx_alarm_clear),
      .abs_pos_enabled(abs_pos_enabled), .homing_done(homing_done),
      .op_start(op_start), .warn_detail_in(wdi), .err_detail_in(edi),
      .latch_clear(latch_clear), .endless_feed_enable_q(feed),
      .object_attribute_select_q(attr), .rx_mappable_q(rxm),
      .tx_mappable_q(txm), .cycle_time_out_q(cto), .cycle_time_in_q(cti),
      .parameter_error_alarm_q(perr), .receive_data_error_alarm_q(rxerr),
      .homing_incomplete_warning_q(hwarn), .sync_err_count_q(cnt),
      .active_warn_q(awarn), .latched_warn_q(lwarn), .active_err_q(aerr),
      .latched_err_q(lerr));
   ncss_master_model i_ncss_master_model (.clk(clk), .rst(rst), .go(go),
      .miss_mask(miss_mask), .n_ev(n_ev), .ow_go(ow_go), .ow_idx(ow_idx),
      .ow_data(ow_data), .sync_event(sync_event), .pdo_updated(pdo_updated),
      .obj_wr(obj_wr), .obj_idx(obj_idx), .obj_wdata(obj_wdata),
      .busy(busy));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic prm_write(input logic [2:0] i, input logic [31:0] d);
      @(posedge clk);
      prm_wr <= 1'b1; prm_idx <= i; prm_wdata <= d;
      @(posedge clk);
      prm_wr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic prm_read(input logic [2:0] i, output logic [31:0] d);
      int n;
      @(posedge clk);
      prm_rd <= 1'b1; prm_idx <= i;
      n = 0;
      do begin
         @(posedge clk); prm_rd <= 1'b0; #1; n++;
      end while (rvalid !== 1'b1 && n < 4);
      if (rvalid !== 1'b1) begin fails++; give_verdict(); end
      d = rdata;
   endtask
   task automatic obj_write(input logic [1:0] i, input logic [31:0] d);
      @(posedge clk);
      ow_go <= 1'b1; ow_idx <= i; ow_data <= d;
      @(posedge clk);
      ow_go <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic run(input logic [7:0] m, input logic [3:0] n);
      int k;
      @(posedge clk);
      go <= 1'b1; miss_mask <= m; n_ev <= n;
      @(posedge clk);
      go <= 1'b0;
      #1;
      for (k = 0; k < 40 && busy !== 1'b0; k++) begin
         @(posedge clk); #1;
      end
      if (busy !== 1'b0) begin fails++; give_verdict(); end
      @(posedge clk); #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {prm_wr, prm_rd, rx_alarm_clear, abs_pos_enabled, homing_done} = '0;
      {op_start, latch_clear, go, ow_go, ow_idx, prm_idx, n_ev} = '0;
      {miss_mask, prm_wdata, ow_data, wdi, edi} = '0;
      fails = 0; total_checks = 0;
      rows = '{'{CYC_AUTO, NS_250US, 1'b0}, '{CYC_125US, NS_125US, 1'b0},
         '{CYC_250US, NS_250US, 1'b0}, '{CYC_500US, NS_500US, 1'b0},
         '{CYC_1MS, NS_1MS, 1'b0}, '{CYC_2MS, NS_2MS, 1'b0},
         '{CYC_4MS, NS_4MS, 1'b0}, '{CYC_8MS, NS_8MS, 1'b0},
         '{8'h03, NS_8MS, 1'b1}, '{8'h0b, NS_8MS, 1'b1}};
      rst = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      // Reset values
      prm_read(3'h3, v); chk(v, 32'h0000_0009);
      prm_read(3'h4, v); chk(v, 32'h0fff_ffff);
      prm_read(3'h5, v); chk(v, 32'h0fff_ffff);
      chk(cto, NS_250US);
      chk({rxm, txm}, 10'h3e0);
      $display("test reset done");
      // Cycle code table; unsupported codes keep the old period
      foreach (rows[r]) begin
         prm_write(3'h2, {24'h0, rows[r].code});
         chk(cto, rows[r].ns);
         chk(cti, rows[r].ns);
         chk(perr, rows[r].alarm);
      end
      prm_read(3'h6, v); chk(v, NS_8MS);
      $display("test cycle table done");
      obj_write(OBJ_CYCLE_TIME, NS_500US);
      chk(cti, NS_500US);
      prm_write(3'h2, 32'h0);
      chk(cto, NS_250US);
      chk(perr, 1'b0);
      $display("test cycle objects done");
      // Feed select and homing warning
      abs_pos_enabled <= 1'b1;
      prm_write(3'h0, 32'h1);
      chk(feed, 1'b1);
      chk(hwarn, 1'b0);
      op_start <= 1'b1; @(posedge clk); op_start <= 1'b0;
      repeat (2) @(posedge clk); #1;
      chk(hwarn, 1'b1);
      homing_done <= 1'b1; @(posedge clk); homing_done <= 1'b0;
      $display("test feed done");
      // Attribute select both ways
      prm_write(3'h1, 32'h0000_1000);
      chk(attr, 1'b1);
      chk({rxm, txm}, {MAP_OLD_RX, MAP_OLD_TX});
      prm_write(3'h1, 32'h0);
      chk({rxm, txm}, {MAP_NEW_RX, MAP_NEW_TX});
      $display("test attributes done");
      // Sync supervision walk, hold, clear, floor, disable
      run(8'h55, 4'h7);
      chk(cnt, 15'h9);
      chk(rxerr, 1'b1);
      run(8'h00, 4'h2);
      chk(cnt, 15'h9);
      rx_alarm_clear <= 1'b1; @(posedge clk); rx_alarm_clear <= 1'b0;
      run(8'h00, 4'h1);
      chk(cnt, 15'h0);
      run(8'h01, 4'h2);
      chk(cnt, 15'h2);
      obj_write(OBJ_SYNC_LIMIT, 32'h0);
      run(8'hff, 4'h8);
      chk({rxerr, cnt}, 16'h0);
      prm_read(3'h3, v); chk(v, 32'h0);
      $display("test sync done");
      // Detail masks from both ports
      wdi <= 32'h1234_5678;
      edi <= 32'h0000_abcd;
      obj_write(OBJ_WARN_MASK, 32'h0000_ff00);
      latch_clear <= 1'b1; @(posedge clk); latch_clear <= 1'b0;
      repeat (2) @(posedge clk); #1;
      chk(awarn, 32'h0000_5600);
      chk(lwarn, 32'h0000_5600);
      prm_write(3'h5, 32'h0000_0f0f);
      chk(aerr, 32'h0000_0b0d);
      chk(lerr, 32'h0000_abcd);
      $display("test masks done");
      give_verdict();
   end
endmodule
`default_nettype wire
